// *** hdl/page_video_seq.sv ***
/*
 * Page-level sequencer facing the image formatter: ready report, print
 * command intake, scanner start, horizontal and vertical sync, and
 * per-colour laser gating from video data.
 * Assumes all inputs synchronous to clk; the formatter pulses the print
 * command for one cycle and drives video aligned to line sync.
 * Only one further command is held during a page; the ready output drops
 * while it waits, so a third command is refused rather than lost.
 * Line sync runs from spin-up to page end, so the formatter can count
 * lines before the page sync arrives.
 * Each plane is exposed for PAGE_LINES lines, yellow's first one cut short as it starts at page sync; planes never overlap.
 * A command taken in the cycle a page ends starts the next page itself.
 */
`timescale 1ns/100ps
`default_nettype none

module page_video_seq #(
  parameter int LINE_CYCLES = video_seq_pkg::LINE_CYCLES_DEF,
  parameter int SPIN_LINES  = video_seq_pkg::SPIN_LINES_DEF,
  parameter int PAGE_LINES  = video_seq_pkg::PAGE_LINES_DEF
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // engine condition
  input  wire logic       engine_able,
  input  wire logic       page_top_sensor,
  // status/command line
  input  wire logic       status_command_line_print,
  output logic            status_command_line_ready,
  // mechanism control
  output logic            scanner_run,
  output logic            pickup_start,
  // sync to formatter
  output logic            hsync,
  output logic            page_vsync,
  // video and lasers
  input  wire logic [3:0] video_in,
  output logic [3:0]      laser_on,
  output logic [1:0]      active_plane
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SPIN,
    ST_PICKUP,
    ST_EXPOSE
  } state_t;

  // ==========================================================================
  // state and counters
  state_t                             state_q, state_d;
  logic [video_seq_pkg::CNT_W-1:0]    hcnt_q, hcnt_d;
  logic [video_seq_pkg::CNT_W-1:0]    lcnt_q, lcnt_d;
  logic [1:0]                         plane_q, plane_d;
  logic                               pend_q, pend_d;
  logic                               sensor_q;
  logic                               ready_q;
  logic                               scan_q;
  logic                               pick_q;
  logic                               hs_q;
  logic                               vs_q;
  logic [3:0]                         laser_q;

  localparam logic [video_seq_pkg::CNT_W-1:0] LINE_LAST =
    video_seq_pkg::CNT_W'(LINE_CYCLES - 1);
  localparam logic [video_seq_pkg::CNT_W-1:0] SPIN_LAST =
    video_seq_pkg::CNT_W'(SPIN_LINES - 1);
  localparam logic [video_seq_pkg::CNT_W-1:0] PAGE_LAST =
    video_seq_pkg::CNT_W'(PAGE_LINES - 1);
  localparam logic [3:0]                      LASER_OFF = 4'h0;

  // ==========================================================================
  // one-hot laser mask of a colour plane
  function automatic logic [3:0] plane_mask(input logic [1:0] plane);
    plane_mask = 4'h1 << plane;
  endfunction

  // ==========================================================================
  // decode
  wire active     = (state_q != ST_IDLE);
  wire line_end   = active && (hcnt_q == LINE_LAST);
  wire cmd_take   = status_command_line_print && ready_q;
  wire sensor_hit = page_top_sensor && !sensor_q;
  wire spin_done  = (state_q == ST_SPIN) && line_end && (lcnt_q == SPIN_LAST);
  wire plane_done = (state_q == ST_EXPOSE) && line_end && (lcnt_q == PAGE_LAST);
  wire page_done  = plane_done && (plane_q == video_seq_pkg::PLANE_BLACK);

  // ==========================================================================
  // output decode
  wire       ready_d = engine_able && !pend_d;
  wire       scan_d  = (state_d != ST_IDLE);
  wire       pick_d  = (state_d == ST_PICKUP);
  wire       hs_d    = line_end;
  wire       vs_d    = (state_q == ST_PICKUP) && sensor_hit;
  wire [3:0] laser_d = (state_q == ST_EXPOSE) ? (video_in & plane_mask(plane_q)) : LASER_OFF;

  // ==========================================================================
  // next state
  always_comb begin
    state_d = state_q;
    hcnt_d  = line_end ? video_seq_pkg::CNT_ZERO : hcnt_q + video_seq_pkg::CNT_ONE;
    lcnt_d  = line_end ? lcnt_q + video_seq_pkg::CNT_ONE : lcnt_q;
    plane_d = plane_q;
    pend_d  = pend_q;
    if (!active) begin
      hcnt_d = video_seq_pkg::CNT_ZERO;
      lcnt_d = video_seq_pkg::CNT_ZERO;
    end
    if (page_done) begin
      pend_d = 1'b0;
    end
    if (cmd_take && active && !page_done) begin
      pend_d = 1'b1;
    end
    case (state_q)
      ST_IDLE: begin
        if (cmd_take) begin
          state_d = ST_SPIN;
        end
      end
      ST_SPIN: begin
        if (spin_done) begin
          state_d = ST_PICKUP;
        end
      end
      ST_PICKUP: begin
        if (sensor_hit) begin
          state_d = ST_EXPOSE;
          plane_d = video_seq_pkg::PLANE_YELLOW;
          lcnt_d  = video_seq_pkg::CNT_ZERO;
        end
      end
      ST_EXPOSE: begin
        if (plane_done) begin
          lcnt_d = video_seq_pkg::CNT_ZERO;
          plane_d = plane_q + 2'h1;
        end
        if (page_done) begin
          state_d = (pend_q || (cmd_take && active)) ? ST_PICKUP : ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q  <= ST_IDLE;
      hcnt_q   <= video_seq_pkg::CNT_ZERO;
      lcnt_q   <= video_seq_pkg::CNT_ZERO;
      plane_q  <= video_seq_pkg::PLANE_YELLOW;
      pend_q   <= 1'b0;
      sensor_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      hcnt_q   <= hcnt_d;
      lcnt_q   <= lcnt_d;
      plane_q  <= plane_d;
      pend_q   <= pend_d;
      sensor_q <= page_top_sensor;
    end
  end

  // ==========================================================================
  // registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
      scan_q  <= 1'b0;
      pick_q  <= 1'b0;
      hs_q    <= 1'b0;
      vs_q    <= 1'b0;
      laser_q <= 4'h0;
    end else begin
      // ready while able and no page queued
      ready_q <= ready_d;
      // scanner runs whenever a print is in progress
      scan_q  <= scan_d;
      // pickup request while waiting for sheet
      pick_q  <= pick_d;
      hs_q    <= hs_d;
      vs_q    <= vs_d;
      laser_q <= laser_d;
    end
  end

  assign status_command_line_ready = ready_q;
  assign scanner_run               = scan_q;
  assign pickup_start              = pick_q;
  assign hsync                     = hs_q;
  assign page_vsync                = vs_q;
  assign laser_on                  = laser_q;
  assign active_plane              = plane_q;

endmodule

`default_nettype wire

// *** inc/video_seq_pkg.sv ***
/*
 * Constants for the page video sequencer: colour plane codes, default
 * line timing and page length.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package video_seq_pkg;

  // ==========================================================================
  // colour planes, in the order they go onto the sheet
  localparam logic [1:0] PLANE_YELLOW  = 2'h0;
  localparam logic [1:0] PLANE_CYAN    = 2'h1;
  localparam logic [1:0] PLANE_MAGENTA = 2'h2;
  localparam logic [1:0] PLANE_BLACK   = 2'h3;
  localparam int         NUM_PLANES    = 4;

  // ==========================================================================
  // default timing, in clock cycles or lines
  localparam int LINE_CYCLES_DEF = 64;
  localparam int SPIN_LINES_DEF  = 8;
  localparam int PAGE_LINES_DEF  = 16;
  localparam int CNT_W           = 16;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

endpackage

`default_nettype wire

// *** verif/fmt_model.sv ***
/* formatter model: print command and video; clk shared with the block */
`timescale 1ns/100ps
`default_nettype none
module fmt_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic       ready,
  input  wire logic       vsync,
  output logic            print,
  output logic [3:0]      video
);
  logic [3:0] vid_q;
  logic       en_q;
  assign print = go & ready;
  // video only after page sync, toggling each cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      vid_q <= 4'hA;
      en_q  <= 1'b0;
    end else begin
      vid_q <= ~vid_q;
      en_q  <= en_q | vsync;
    end
  end
  assign video = en_q ? vid_q : 4'h0;
endmodule
`default_nettype wire

// *** verif/pvs_monitor.sv ***
/* port checker for page_video_seq; bound to every instance */
`timescale 1ns/100ps
`default_nettype none
module pvs_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       engine_able,
  input wire logic       page_top_sensor,
  input wire logic       status_command_line_print,
  input wire logic       status_command_line_ready,
  input wire logic       scanner_run,
  input wire logic       pickup_start,
  input wire logic       hsync,
  input wire logic       page_vsync,
  input wire logic [3:0] video_in,
  input wire logic [3:0] laser_on,
  input wire logic [1:0] active_plane
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ready_needs_able: assert property (!engine_able |=> !status_command_line_ready) else $error("ready");
  a_cmd_starts_scan: assert property (status_command_line_print && status_command_line_ready && !scanner_run
    |=> scanner_run) else $error("scanner");
  a_sensor_gives_vsync: assert property ($rose(page_top_sensor) && pickup_start |=> page_vsync) else $error("vs");
  a_vsync_ends_pickup: assert property (page_vsync |-> !pickup_start) else $error("pickup");
  a_laser_follows_video: assert property ((laser_on & ~$past(video_in)) == 4'h0) else $error("laser");
  a_plane_order_kept: assert property ($changed(active_plane) |-> active_plane == $past(active_plane) + 2'h1)
    else $error("plane");
  a_queued_no_idle: assert property (!status_command_line_ready && $past(engine_able) && scanner_run
    |=> scanner_run)
    else $error("chain");
  a_idle_no_sync: assert property (!scanner_run && !$past(scanner_run) |-> !hsync && !page_vsync) else $error("sync");
endmodule
bind page_video_seq pvs_monitor mon (.*);
`default_nettype wire

// *** verif/test_page_video_seq.sv ***
/* bench for page_video_seq; formatter model drives command and video */
`timescale 1ns/100ps
`default_nettype none
module test_page_video_seq;
  logic clk = 0, sys_rst = 1, engine_able = 0, page_top_sensor = 0, go = 0;
  logic print, ready, scan, pick, hs, vs;
  logic [3:0] video, laser;
  logic [1:0] plane;
  int mismatches = 0, n_checks = 0;
  always #2 clk = ~clk;
  page_video_seq #(.LINE_CYCLES(4), .SPIN_LINES(2), .PAGE_LINES(2)) uut (.clk(clk), .sys_rst(sys_rst),
    .engine_able(engine_able), .page_top_sensor(page_top_sensor), .status_command_line_print(print),
    .status_command_line_ready(ready), .scanner_run(scan), .pickup_start(pick), .hsync(hs),
    .page_vsync(vs), .video_in(video), .laser_on(laser), .active_plane(plane));
  fmt_model fm (.clk(clk), .rst(sys_rst), .go(go), .ready(ready), .vsync(vs), .print(print), .video(video));
  task automatic check(logic [3:0] seen, logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic refuse;
    @(negedge clk) go = 1;
    @(negedge clk) go = 0;
    check(scan, 4'h0);
    engine_able = 1;
    repeat (2) @(negedge clk);
    check(ready, 4'h1);
    $display("refuse done");
  endtask
  task automatic page(bit start, bit chain);
    logic [3:0] pv, lz;
    logic [1:0] ep, np;
    int h;
    lz = 4'h0;
    ep = 2'h0;
    h = 0;
    if (start) begin
      @(negedge clk) go = 1;
      @(negedge clk) go = 0;
      check(scan, 4'h1);
    end
    for (int i = 0; i < 60 && !pick; i++) @(negedge clk);
    check(pick, 4'h1);
    page_top_sensor = 1;
    @(negedge clk);
    check(vs, 4'h1);
    page_top_sensor = 0;
    for (int i = 0; i < 40; i++) begin
      pv = video;
      go = chain && i == 10;
      @(negedge clk);
      if (i < 32 && hs) h++;
      lz |= laser;
      check(laser & ~pv, 4'h0);
      if (chain && i == 12) check(ready, 4'h0);
      np = ep + 2'h1;
      if (plane !== ep) begin
        check({2'h0, plane}, {2'h0, np});
        ep = plane;
      end
    end
    check(lz, 4'hF);
    check(4'(h), 4'h8);
    check(scan, {3'h0, chain});
    check(ready, 4'h1);
    if (!chain) check(hs, 4'h0);
    $display("page done");
  endtask
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 0;
    refuse();
    page(1, 0);
    page(1, 1);
    page(0, 0);
    conclude();
  end
endmodule
`default_nettype wire
